/* File: mcrm_pkg.sv */
// Package with register map, field positions, reset values and timing for the mode control block
// ****************************************************************
// Function
// - Debug pin and mode pins latched into mode bits at reset release.
// - Special flag writable only while zero; first write after reset ignored.
// - Mode select: once if normal, anytime if special; peripheral/reserved refused.
// - Special single-chip: skip vector fetch, debug firmware controls, no external bus.
// - Special peripheral: CPU idle, entered/left only by reset, no debug use.
// - Special narrow: 16-bit external transfer as high then low byte cycles.
// - Special wide: control port bus pins serve as bus-control outputs.
// - Active debug: ROM overlays FF00-FFFF, debug registers FF00-FF06.
// - Debug active from reset in special single-chip; else enable then activate.
// - Debug accesses internal resources using idle bus cycles.
// - Stretch enable: 0 free-running, 1 stretches; reads 1 in expanded modes.
// - Visibility in special narrow shows internal accesses wide; ignored normal narrow.
// - Visibility and port emulation: once normal, anytime special except first.
// - External bus stop-in-wait shuts bus in wait after a drain delay.
// - Port emulation in expanded modes unmaps port E registers; single-chip keeps them.
// - Register block position: once in normal modes, anytime special; readable.
// - Mapping write takes effect one cycle later; software follows with no-op.
// - Decode priority: debug ROM, registers, RAM, EEPROM, flash, external.
// - Expanded modes: unclaimed addresses decode as external memory.
// - 512-byte register block at 0000 after reset, movable on 2K boundaries.
// - Map interface stop-in-wait shuts mapping access during wait.
// - Mode register absent from map in special peripheral mode.
// - Mode decode of debug, B, A pins into eight modes; reserved forced peripheral.
// ****************************************************************
package mcrm_pkg;
    // Register offsets within the register block
    localparam logic [8:0] OFS_MODE = 9'h00b;
    localparam logic [8:0] OFS_REG_POS = 9'h011;
    localparam logic [8:0] OFS_PORT_E_DATA_REG = 9'h008;
    localparam logic [8:0] OFS_PORT_E_DIRECTION_REG = 9'h009;
    // Mode register fields
    localparam int B_SPEC_N = 7;
    localparam int B_MODE_SELECT_HI = 6;
    localparam int B_MODE_SELECT_LO = 5;
    localparam int B_BUS_CLOCK_STRETCH_ENABLE = 4;
    localparam int B_INTERNAL_VISIBILITY = 3;
    localparam int B_EXT_BUS_STOP_IN_WAIT = 2;
    localparam int B_EME = 0;
    // Register position fields
    localparam int B_MAP_IFACE_STOP_IN_WAIT = 0;
    localparam logic [7:0] REG_POS_RST = 8'h00;
    localparam logic [7:0] REG_POS_MASK = 8'hf9;
    // Debug ROM window
    localparam logic [15:0] DBG_ROM_BASE = 16'hff00;
    localparam logic [15:0] DBG_REG_LAST = 16'hff06;
    // External bus drain delay before wait shutdown
    localparam int DRAIN_NS = 100;
    localparam int CLK_NS = 20;
    localparam int DRAIN_CYC = (DRAIN_NS + CLK_NS - 1) / CLK_NS;
    typedef enum logic [2:0] {
        MD_SPEC_SC = 3'h0, MD_SPEC_NAR = 3'h1, MD_SPEC_PER = 3'h2, MD_SPEC_WIDE = 3'h3,
        MD_NORM_SC = 3'h4, MD_NORM_NAR = 3'h5, MD_RESERVED = 3'h6, MD_NORM_WIDE = 3'h7
    } mcrm_mode_e;
    typedef enum logic [2:0] {
        SEL_DBG, SEL_REG, SEL_RAM, SEL_EE, SEL_FLASH, SEL_EXT, SEL_NONE
    } mcrm_sel_e;
endpackage

/* File: mcrm_top.sv */
// Mode control, register block mapping and address precedence decoder
module mcrm_top #(
    parameter int ADDR_W = 16
) (
    // Clock, reset, enable
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    // Mode pins, asynchronous, sampled on core_clk_i through a two-flop synchroniser
    input wire logic serial_debug_pin_i,
    input wire logic mode_b_pin_i,
    input wire logic mode_a_pin_i,
    // Register port
    input wire logic [8:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // CPU access and other resource windows
    input wire logic [ADDR_W-1:0] cpu_addr_i,
    input wire logic cpu_access_i,
    input wire logic cpu_wide_i,
    input wire logic cpu_external_i,
    input wire logic ram_hit_i,
    input wire logic ee_hit_i,
    input wire logic flash_hit_i,
    // Debug and wait
    input wire logic debug_enable_i,
    input wire logic debug_activate_i,
    input wire logic debug_exit_i,
    input wire logic debug_idle_req_i,
    input wire logic cpu_bus_idle_i,
    input wire logic wait_mode_i,
    // Selects and status
    output logic sel_dbg_rom_o,
    output logic sel_reg_o,
    output logic sel_ram_o,
    output logic sel_ee_o,
    output logic sel_flash_o,
    output logic sel_ext_o,
    output logic [2:0] mode_o,
    output logic debug_active_o,
    output logic skip_reset_vector_o,
    output logic cpu_halt_o,
    output logic debug_grant_o,
    output logic split_narrow_o,
    output logic visible_wide_o,
    output logic bus_ctrl_outputs_o,
    output logic bus_clock_stretch_enable_o,
    output logic ext_bus_off_o,
    output logic map_iface_off_o,
    output logic port_e_mapped_o
);
    // ****************************************************************
    // Pin synchronisers and reset latch
    // ****************************************************************
    logic [2:0] pin_meta_q, pin_sync_q;
    logic latched_q;
    logic [1:0] boot_q;
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_meta_q <= 3'h0;
            pin_sync_q <= 3'h0;
        end else if (clk_en_i) begin
            pin_meta_q <= {serial_debug_pin_i, mode_b_pin_i, mode_a_pin_i};
            pin_sync_q <= pin_meta_q;
        end
    end

    // ****************************************************************
    // Mode register state
    // ****************************************************************
    logic spec_n_q, mode_select_hi_q, mode_select_lo_q, bus_clock_stretch_enable_q, internal_visibility_q, ext_bus_stop_in_wait_q, eme_q;
    logic spec_wr_seen_q, mode_wr_done_q, internal_visibility_wr_q, eme_wr_q, bus_clock_stretch_enable_wr_q, pos_wr_q;
    logic [4:0] reg_pos_q;
    logic map_iface_stop_in_wait_q;
    logic dbg_active_q;
    logic [2:0] drain_q;

    wire [2:0] mode_now = {spec_n_q, mode_select_hi_q, mode_select_lo_q};
    wire is_special = !spec_n_q;
    wire is_periph = (mode_now == mcrm_pkg::MD_SPEC_PER);
    wire is_single = !mode_select_hi_q && !mode_select_lo_q;
    wire is_expanded = !is_single && !is_periph;
    wire is_narrow = !mode_select_hi_q && mode_select_lo_q;

    wire wr_mode = latched_q && clk_en_i && reg_wr_i && !is_periph && reg_addr_i == mcrm_pkg::OFS_MODE;
    wire wr_pos = latched_q && clk_en_i && reg_wr_i && reg_addr_i == mcrm_pkg::OFS_REG_POS;
    wire [2:0] req_mode = {reg_wdata_i[mcrm_pkg::B_SPEC_N], reg_wdata_i[mcrm_pkg::B_MODE_SELECT_HI],
        reg_wdata_i[mcrm_pkg::B_MODE_SELECT_LO]};
    wire req_bad = req_mode[1] && !req_mode[0];
    wire mode_ok = wr_mode && !req_bad && (is_special || !mode_wr_done_q);
    wire spec_ok = wr_mode && is_special && spec_wr_seen_q && !req_bad;
    wire once_ok = is_special ? 1'b1 : 1'b0;

    function automatic logic bit_ok(input logic special, input logic done, input logic seen);
        bit_ok = special ? seen : !done;
    endfunction

    wire internal_visibility_ok = wr_mode && bit_ok(is_special, internal_visibility_wr_q, internal_visibility_wr_q);
    wire eme_ok = wr_mode && bit_ok(is_special, eme_wr_q, eme_wr_q);
    wire bus_clock_stretch_enable_ok = wr_mode && (is_special || !bus_clock_stretch_enable_wr_q);
    wire pos_ok = wr_pos && (once_ok || !pos_wr_q);

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            latched_q <= 1'b0;
            boot_q <= 2'h0;
            spec_n_q <= 1'b1;
            mode_select_hi_q <= 1'b0;
            mode_select_lo_q <= 1'b0;
            bus_clock_stretch_enable_q <= 1'b1;
            internal_visibility_q <= 1'b0;
            ext_bus_stop_in_wait_q <= 1'b0;
            eme_q <= 1'b0;
            spec_wr_seen_q <= 1'b0;
            mode_wr_done_q <= 1'b0;
            internal_visibility_wr_q <= 1'b0;
            eme_wr_q <= 1'b0;
            bus_clock_stretch_enable_wr_q <= 1'b0;
            pos_wr_q <= 1'b0;
            reg_pos_q <= 5'h00;
            map_iface_stop_in_wait_q <= 1'b0;
        end else if (clk_en_i) begin
            if (!latched_q) begin
                // Synchroniser needs two edges before it holds the pin levels
                boot_q <= boot_q + 2'h1;
                if (boot_q == 2'h2) begin
                    latched_q <= 1'b1;
                    spec_n_q <= pin_sync_q[2];
                    mode_select_hi_q <= pin_sync_q[1];
                    mode_select_lo_q <= pin_sync_q[0];
                    if (pin_sync_q == mcrm_pkg::MD_RESERVED) begin
                        spec_n_q <= 1'b0;
                        mode_select_hi_q <= 1'b1;
                        mode_select_lo_q <= 1'b0;
                    end
                    internal_visibility_q <= !pin_sync_q[2] || (pin_sync_q == mcrm_pkg::MD_RESERVED);
                    eme_q <= !pin_sync_q[2] || (pin_sync_q == mcrm_pkg::MD_RESERVED);
                end
            end else begin
                if (wr_mode) begin
                    spec_wr_seen_q <= 1'b1;
                    internal_visibility_wr_q <= 1'b1;
                    eme_wr_q <= 1'b1;
                    bus_clock_stretch_enable_wr_q <= 1'b1;
                    mode_wr_done_q <= 1'b1;
                    ext_bus_stop_in_wait_q <= reg_wdata_i[mcrm_pkg::B_EXT_BUS_STOP_IN_WAIT];
                end
                if (spec_ok) begin
                    spec_n_q <= reg_wdata_i[mcrm_pkg::B_SPEC_N];
                end
                if (mode_ok) begin
                    mode_select_hi_q <= reg_wdata_i[mcrm_pkg::B_MODE_SELECT_HI];
                    mode_select_lo_q <= reg_wdata_i[mcrm_pkg::B_MODE_SELECT_LO];
                end
                if (internal_visibility_ok) begin
                    internal_visibility_q <= reg_wdata_i[mcrm_pkg::B_INTERNAL_VISIBILITY];
                end
                if (eme_ok) begin
                    eme_q <= reg_wdata_i[mcrm_pkg::B_EME];
                end
                if (bus_clock_stretch_enable_ok) begin
                    bus_clock_stretch_enable_q <= reg_wdata_i[mcrm_pkg::B_BUS_CLOCK_STRETCH_ENABLE];
                end
                if (wr_pos) begin
                    pos_wr_q <= 1'b1;
                    map_iface_stop_in_wait_q <= reg_wdata_i[mcrm_pkg::B_MAP_IFACE_STOP_IN_WAIT];
                end
                if (pos_ok) begin
                    reg_pos_q <= reg_wdata_i[7:3];
                end
            end
        end
    end

    // ****************************************************************
    // Debug activation and map settling
    // ****************************************************************
    // Mapping writes reach the decoder one cycle later, decoding with the old map meanwhile
    logic [4:0] reg_pos_eff_q;
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dbg_active_q <= 1'b0;
            reg_pos_eff_q <= 5'h00;
            drain_q <= 3'h0;
        end else if (clk_en_i) begin
            reg_pos_eff_q <= reg_pos_q;
            if (!latched_q) begin
                dbg_active_q <= (boot_q == 2'h2) && (pin_sync_q == mcrm_pkg::MD_SPEC_SC);
            end else if (debug_exit_i) begin
                dbg_active_q <= 1'b0;
            end else if (debug_enable_i && debug_activate_i && !is_periph) begin
                dbg_active_q <= 1'b1;
            end
            if (!wait_mode_i || !ext_bus_stop_in_wait_q) begin
                drain_q <= 3'h0;
            end else if (drain_q != 3'(mcrm_pkg::DRAIN_CYC)) begin
                drain_q <= drain_q + 3'h1;
            end
        end
    end

    // ****************************************************************
    // Address precedence decoder
    // ****************************************************************
    wire hit_dbg = dbg_active_q && (cpu_addr_i >= mcrm_pkg::DBG_ROM_BASE);
    wire hit_reg = (cpu_addr_i[15:11] == reg_pos_eff_q) && (cpu_addr_i[10:9] == 2'h0);
    wire dbg_reg_win = hit_dbg && (cpu_addr_i <= mcrm_pkg::DBG_REG_LAST);
    wire map_off = map_iface_stop_in_wait_q && wait_mode_i;
    wire [2:0] sel_w = !cpu_access_i || map_off ? mcrm_pkg::SEL_NONE :
        hit_dbg ? mcrm_pkg::SEL_DBG :
        hit_reg ? mcrm_pkg::SEL_REG :
        ram_hit_i ? mcrm_pkg::SEL_RAM :
        ee_hit_i ? mcrm_pkg::SEL_EE :
        flash_hit_i ? mcrm_pkg::SEL_FLASH :
        is_expanded ? mcrm_pkg::SEL_EXT : mcrm_pkg::SEL_NONE;

    // ****************************************************************
    // Read data and registered outputs
    // ****************************************************************
    wire [7:0] mode_rd = {spec_n_q, mode_select_hi_q, mode_select_lo_q, bus_clock_stretch_enable_q | is_expanded, internal_visibility_q, ext_bus_stop_in_wait_q, 1'b0, eme_q};
    wire [7:0] rd_w = (reg_addr_i == mcrm_pkg::OFS_MODE && !is_periph) ? mode_rd :
        (reg_addr_i == mcrm_pkg::OFS_REG_POS) ? ({reg_pos_q, 3'h0} | {7'h00, map_iface_stop_in_wait_q}) : 8'h00;
    wire pe_mapped = is_single || (!is_periph && !eme_q);

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= 8'h00;
            sel_dbg_rom_o <= 1'b0;
            sel_reg_o <= 1'b0;
            sel_ram_o <= 1'b0;
            sel_ee_o <= 1'b0;
            sel_flash_o <= 1'b0;
            sel_ext_o <= 1'b0;
            mode_o <= 3'h4;
            debug_active_o <= 1'b0;
            skip_reset_vector_o <= 1'b0;
            cpu_halt_o <= 1'b0;
            debug_grant_o <= 1'b0;
            split_narrow_o <= 1'b0;
            visible_wide_o <= 1'b0;
            bus_ctrl_outputs_o <= 1'b0;
            bus_clock_stretch_enable_o <= 1'b1;
            ext_bus_off_o <= 1'b0;
            map_iface_off_o <= 1'b0;
            port_e_mapped_o <= 1'b1;
        end else if (clk_en_i) begin
            reg_rdata_o <= reg_rd_i ? rd_w : 8'h00;
            sel_dbg_rom_o <= sel_w == mcrm_pkg::SEL_DBG;
            sel_reg_o <= sel_w == mcrm_pkg::SEL_REG;
            sel_ram_o <= sel_w == mcrm_pkg::SEL_RAM;
            sel_ee_o <= sel_w == mcrm_pkg::SEL_EE;
            sel_flash_o <= sel_w == mcrm_pkg::SEL_FLASH;
            sel_ext_o <= sel_w == mcrm_pkg::SEL_EXT;
            mode_o <= mode_now;
            debug_active_o <= dbg_active_q && !dbg_reg_win ? 1'b1 : dbg_active_q;
            skip_reset_vector_o <= latched_q && mode_now == mcrm_pkg::MD_SPEC_SC;
            cpu_halt_o <= is_periph;
            debug_grant_o <= debug_idle_req_i && cpu_bus_idle_i && !is_periph;
            split_narrow_o <= is_narrow && cpu_external_i && cpu_wide_i;
            visible_wide_o <= is_special && is_narrow && internal_visibility_q && !cpu_external_i;
            bus_ctrl_outputs_o <= mode_now == mcrm_pkg::MD_SPEC_WIDE || (is_expanded && is_special);
            bus_clock_stretch_enable_o <= bus_clock_stretch_enable_q | is_expanded;
            ext_bus_off_o <= drain_q == 3'(mcrm_pkg::DRAIN_CYC);
            map_iface_off_o <= map_off;
            port_e_mapped_o <= pe_mapped;
        end
    end
endmodule // mcrm_top

/* File: mcrm_checker.sv */
// Concurrent checks on the mode control block ports
// ****************************************************************
// Checker
// ****************************************************************
module mcrm_checker #(
    parameter int ADDR_W = 16
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    input wire logic reg_rd_i,
    input wire logic [ADDR_W-1:0] cpu_addr_i,
    input wire logic cpu_access_i,
    input wire logic wait_mode_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic sel_dbg_rom_o,
    input wire logic sel_reg_o,
    input wire logic sel_ram_o,
    input wire logic sel_ee_o,
    input wire logic sel_flash_o,
    input wire logic sel_ext_o,
    input wire logic [2:0] mode_o,
    input wire logic debug_active_o,
    input wire logic skip_reset_vector_o,
    input wire logic cpu_halt_o,
    input wire logic bus_clock_stretch_enable_o,
    input wire logic bus_ctrl_outputs_o,
    input wire logic ext_bus_off_o,
    input wire logic map_iface_off_o,
    input wire logic port_e_mapped_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    logic [5:0] sel_w;
    assign sel_w = {sel_dbg_rom_o, sel_reg_o, sel_ram_o, sel_ee_o, sel_flash_o, sel_ext_o};
    sequence s_idle_rd; !(reg_rd_i && clk_en_i); endsequence
    sequence s_no_acc; !cpu_access_i && clk_en_i; endsequence
    sequence s_dbg_acc;
        cpu_access_i && clk_en_i && debug_active_o && cpu_addr_i >= 16'hff00 && !wait_mode_i && !map_iface_off_o;
    endsequence
    property p_one_hot; $onehot0(sel_w); endproperty
    property p_rdata_idle; s_idle_rd |=> reg_rdata_o == 8'h00; endproperty
    property p_no_sel; s_no_acc |=> sel_w == 6'h00; endproperty
    property p_dbg_rom; s_dbg_acc |=> sel_dbg_rom_o; endproperty
    property p_bus_clock_stretch_enable; mode_o[0] |-> bus_clock_stretch_enable_o; endproperty
    property p_wide_ctrl; (mode_o == 3'h3) [*2] |-> bus_ctrl_outputs_o; endproperty
    property p_sc_port_e_data_reg; (mode_o[1:0] == 2'h0) [*2] |-> port_e_mapped_o; endproperty
    property p_map_off; map_iface_off_o |-> $past(wait_mode_i); endproperty
    property p_ext_off; $rose(ext_bus_off_o) |-> $past(wait_mode_i) && $past(wait_mode_i, 3); endproperty
    property p_skip_sc; skip_reset_vector_o |-> mode_o == 3'h0; endproperty
    property p_halt_per; cpu_halt_o |-> mode_o == 3'h2; endproperty
    a_skip_sc: assert property (p_skip_sc) else $error("vector skip outside special single chip");
    a_halt_per: assert property (p_halt_per) else $error("cpu halted outside peripheral mode");
    a_one_hot: assert property (p_one_hot) else $error("more than one select");
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
    a_no_sel: assert property (p_no_sel) else $error("select without access");
    a_dbg_rom: assert property (p_dbg_rom) else $error("debug rom not selected");
    a_bus_clock_stretch_enable: assert property (p_bus_clock_stretch_enable) else $error("stretch enable low in expanded mode");
    a_wide_ctrl: assert property (p_wide_ctrl) else $error("control pins not bus outputs");
    a_sc_port_e_data_reg: assert property (p_sc_port_e_data_reg) else $error("port e unmapped in single chip");
    a_map_off: assert property (p_map_off) else $error("map interface off outside wait");
    a_ext_off: assert property (p_ext_off) else $error("bus off without drain delay");
endmodule // mcrm_checker

bind mcrm_top mcrm_checker #(.ADDR_W(ADDR_W)) u_chk (.core_clk_i, .rst_b_i, .clk_en_i, .reg_rd_i, .cpu_addr_i,
    .cpu_access_i, .wait_mode_i, .reg_rdata_o, .sel_dbg_rom_o, .sel_reg_o, .sel_ram_o, .sel_ee_o, .sel_flash_o,
    .sel_ext_o, .mode_o, .debug_active_o, .skip_reset_vector_o, .cpu_halt_o, .bus_clock_stretch_enable_o, .bus_ctrl_outputs_o,
    .ext_bus_off_o, .map_iface_off_o,
    .port_e_mapped_o);

/* File: mcrm_far_model.sv */
// Model of the memory windows and serial debug host around the block
module mcrm_far_model (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // Address and host requests
    input wire logic [15:0] cpu_addr_i,
    input wire logic host_activate_i,
    input wire logic host_exit_i,
    // Window hits and debug controls
    output logic ram_hit_o,
    output logic ee_hit_o,
    output logic flash_hit_o,
    output logic debug_enable_o,
    output logic debug_activate_o,
    output logic debug_exit_o
);
    assign ram_hit_o = cpu_addr_i inside {[16'h0800:16'h0bff]};
    assign ee_hit_o = cpu_addr_i inside {[16'h0d00:16'h0fff]};
    assign flash_hit_o = cpu_addr_i[15];
    // Enable first, activation only a cycle later, as a real host must
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            debug_enable_o <= 1'b0;
            debug_activate_o <= 1'b0;
            debug_exit_o <= 1'b0;
        end else begin
            debug_enable_o <= debug_enable_o | host_activate_i;
            debug_activate_o <= debug_enable_o & host_activate_i;
            debug_exit_o <= host_exit_i;
        end
    end
endmodule // mcrm_far_model

/* File: mcrm_top_tb_top.sv */
// Self-checking bench for the mode control block
module mcrm_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // Bench
    // ****************************************************************
    logic core_clk_i = 1'b0, rst_b_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, cpu_access_i = 1'b0;
    logic cpu_wide_i = 1'b0, cpu_external_i = 1'b0, wait_mode_i = 1'b0, host_act = 1'b0, host_exit = 1'b0;
    logic [8:0] reg_addr_i = 9'h000;
    logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o;
    logic [15:0] cpu_addr_i = 16'h0000;
    logic ram_hit, ee_hit, flash_hit, dbg_en, dbg_act, dbg_exit, bus_clock_stretch_enable_o, ext_off, map_off, pe_map, bus_ctrl;
    logic s_dbg, s_reg, s_ram, s_ee, s_flash, s_ext;
    logic [2:0] mode_o;
    logic idle_req = 1'b0, bus_idle = 1'b0, dbg_on = 1'b0, dbg_o, skip, halt, grant, split, vis;
    logic [2:0] md = 3'h3;
    int n_fail = 0, n_tests = 0, cyc = 0;
    always #10 core_clk_i = ~core_clk_i;
    mcrm_far_model far (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .cpu_addr_i(cpu_addr_i),
        .host_activate_i(host_act), .host_exit_i(host_exit), .ram_hit_o(ram_hit), .ee_hit_o(ee_hit),
        .flash_hit_o(flash_hit), .debug_enable_o(dbg_en), .debug_activate_o(dbg_act), .debug_exit_o(dbg_exit));
    // Pins select special expanded wide
    mcrm_top dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .clk_en_i(1'b1), .serial_debug_pin_i(1'b0),
        .mode_b_pin_i(1'b1), .mode_a_pin_i(1'b1), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .cpu_addr_i(cpu_addr_i),
        .cpu_access_i(cpu_access_i), .cpu_wide_i(cpu_wide_i), .cpu_external_i(cpu_external_i),
        .ram_hit_i(ram_hit), .ee_hit_i(ee_hit), .flash_hit_i(flash_hit), .debug_enable_i(dbg_en),
        .debug_activate_i(dbg_act), .debug_exit_i(dbg_exit), .debug_idle_req_i(idle_req), .cpu_bus_idle_i(bus_idle),
        .wait_mode_i(wait_mode_i), .sel_dbg_rom_o(s_dbg), .sel_reg_o(s_reg), .sel_ram_o(s_ram), .sel_ee_o(s_ee),
        .sel_flash_o(s_flash), .sel_ext_o(s_ext), .mode_o(mode_o), .debug_active_o(dbg_o), .skip_reset_vector_o(skip),
        .cpu_halt_o(halt), .debug_grant_o(grant), .split_narrow_o(split), .visible_wide_o(vis),
        .bus_ctrl_outputs_o(bus_ctrl),
        .bus_clock_stretch_enable_o(bus_clock_stretch_enable_o), .ext_bus_off_o(ext_off), .map_iface_off_o(map_off), .port_e_mapped_o(pe_map));
    function automatic logic [5:0] exp_sel(logic [15:0] a, logic [4:0] p, logic d);
        if (d && a >= 16'hff00) return 6'h20;
        if (a[15:11] == p && a[10:9] == 2'h0) return 6'h10;
        if (a inside {[16'h0800:16'h0bff]}) return 6'h08;
        if (a inside {[16'h0d00:16'h0fff]}) return 6'h04;
        if (a[15]) return 6'h02;
        return 6'h01;
    endfunction
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic cmp_sel(input logic [5:0] e);
        cmp({2'h0, s_dbg, s_reg, s_ram, s_ee, s_flash, s_ext}, {2'h0, e});
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        // Mapping writes settle over two cycles
        repeat (3) @(posedge core_clk_i);
    endtask
    task automatic rd(input logic [8:0] a, input logic [7:0] e);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1 cmp(reg_rdata_o, e);
    endtask
    task automatic dec(input logic [15:0] a, input logic [5:0] e);
        logic [2:0] r;
        r = 3'($urandom);
        @(posedge core_clk_i);
        cpu_addr_i <= a;
        cpu_access_i <= 1'b1;
        cpu_external_i <= e[0];
        cpu_wide_i <= r[2];
        idle_req <= r[1];
        bus_idle <= r[0];
        @(posedge core_clk_i);
        cpu_access_i <= 1'b0;
        #1 cmp_sel(e);
        cmp({2'h0, dbg_o, skip, halt, grant, split, vis},
            {2'h0, dbg_on, 2'h0, &r[1:0], md[1:0] == 2'h1 && e[0] && r[2], md == 3'h1 && !e[0]});
    endtask
    task automatic rnd(input logic [4:0] p);
        logic [15:0] a;
        repeat (150) begin
            a = 16'($urandom);
            dec(a, exp_sel(a, p, 1'b0));
        end
    endtask
    task automatic print_verdict();
        if (n_fail == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            print_verdict();
        end
    end
    initial begin
        void'($urandom(43654));
        repeat (11) @(posedge core_clk_i);
        #1 cmp({5'h0, mode_o}, 8'h04);
        cmp({6'h0, bus_clock_stretch_enable_o, pe_map}, 8'h03);
        @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        repeat (6) @(posedge core_clk_i);
        #1 cmp({5'h0, mode_o}, 8'h03);
        cmp({5'h0, bus_ctrl, bus_clock_stretch_enable_o, pe_map}, 8'h06);
        rd(mcrm_pkg::OFS_MODE, 8'h79);
        rd(mcrm_pkg::OFS_REG_POS, 8'h00);
        dec(16'hff10, 6'h02);
        rnd(5'h00);
        wr(mcrm_pkg::OFS_MODE, 8'h54);
        rd(mcrm_pkg::OFS_MODE, 8'h7d);
        wr(mcrm_pkg::OFS_MODE, 8'h2c);
        md = 3'h1;
        #1 cmp({5'h0, mode_o}, 8'h01);
        rd(mcrm_pkg::OFS_MODE, 8'h3c);
        dec(16'h4000, 6'h01);
        dec(16'h0000, 6'h10);
        wr(mcrm_pkg::OFS_MODE, 8'h7d);
        md = 3'h3;
        rd(mcrm_pkg::OFS_MODE, 8'h7d);
        wr(mcrm_pkg::OFS_REG_POS, 8'hff);
        rd(mcrm_pkg::OFS_REG_POS, 8'hf9);
        wr(mcrm_pkg::OFS_REG_POS, 8'h09);
        rd(mcrm_pkg::OFS_REG_POS, 8'h09);
        dec(16'h0800, 6'h10);
        dec(16'h0a00, 6'h08);
        rnd(5'h01);
        @(posedge core_clk_i);
        wait_mode_i <= 1'b1;
        repeat (8) @(posedge core_clk_i);
        #1 cmp({6'h0, ext_off, map_off}, 8'h03);
        dec(16'h0900, 6'h00);
        @(posedge core_clk_i);
        wait_mode_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        #1 cmp({6'h0, ext_off, map_off}, 8'h00);
        @(posedge core_clk_i);
        host_act <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        host_act <= 1'b0;
        dbg_on = 1'b1;
        repeat (4) @(posedge core_clk_i);
        dec(16'hff10, 6'h20);
        dec(16'h0900, 6'h10);
        @(posedge core_clk_i);
        host_exit <= 1'b1;
        @(posedge core_clk_i);
        host_exit <= 1'b0;
        dbg_on = 1'b0;
        repeat (4) @(posedge core_clk_i);
        dec(16'hff10, 6'h02);
        wr(mcrm_pkg::OFS_MODE, 8'hfd);
        #1 cmp({5'h0, mode_o}, 8'h07);
        print_verdict();
    end
endmodule // mcrm_top_tb_top
